// [common/rmp_regs.vh]
`ifndef RMP_REGS_VH
`define RMP_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define RMP_OFF_CFG_EDIT 8'h00
`define RMP_OFF_CONFIRM 8'h04
`define RMP_OFF_CFG_ACT 8'h08
`define RMP_OFF_CTRL 8'h0c
`define RMP_OFF_STATUS 8'h10
`define RMP_OFF_UNIT 8'h14
`define RMP_OFF_TX_DATA 8'h18
`define RMP_OFF_TX_END 8'h1c

// ==========================================================
// Configuration fields (CFG_EDIT and CFG_ACT)
`define RMP_F_IFACE 0
`define RMP_F_ADDR 5:1
`define RMP_F_BAUD 6
`define RMP_F_PTERM 7
`define RMP_F_STERM 8
`define RMP_CFG_W 9
// Serial CR+LF, parallel LF+EOI, 9600, address 1, parallel bus
`define RMP_CFG_RST 9'h102
`define RMP_ADDR_MAX 5'h1e

// ==========================================================
// Other fields
`define RMP_F_ECHO 0
`define RMP_F_CONFIRM 0
`define RMP_F_ST_REMOTE 0
`define RMP_F_ST_BUSY 1
`define RMP_F_ST_RESP 2
`define RMP_F_ST_AREJ 3
`define RMP_F_ST_CERR 4
`define RMP_F_ST_UNITS 15:8

// ==========================================================
// Message buffer and header dictionary
`define RMP_BUF_DEPTH 64
`define RMP_LEN_W 7
`define RMP_DICT_N 4
`define RMP_DICT_STR "HEADER   FREQUENCYBEEPER   KEY      "
// Long and short lengths, four bits each, entry 0 in the top nibbles
`define RMP_DICT_LONG 16'h6963
`define RMP_DICT_SHORT 16'h4443

// ==========================================================
// Characters
`define RMP_CH_LF 8'h0a
`define RMP_CH_CR 8'h0d
`define RMP_CH_SP 8'h20
`define RMP_CH_STAR 8'h2a
`define RMP_CH_COLON 8'h3a
`define RMP_CH_SEMI 8'h3b
`define RMP_CH_QM 8'h3f

`endif

// [logic/rmp_parser.v]
// Our own choices: the placing of the registers and the APB interface to the registers.
`include "rmp_regs.vh"

module rmp_parser (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Parallel bus receive
  input wire [7:0] par_rx_data,
  input wire par_rx_valid,
  input wire par_rx_eoi,
  // Serial link receive
  input wire [7:0] ser_rx_data,
  input wire ser_rx_valid,
  output wire rx_ready,
  // Response transmit
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg tx_eoi,
  input wire tx_ready,
  // Front panel
  input wire confirm_key,
  input wire local_key,
  input wire panel_key,
  output wire panel_key_accept,
  output reg remote_indicator,
  // Active configuration
  output wire parallel_bus_select,
  output wire serial_link_select,
  output wire [4:0] bus_address,
  output wire baud_19200,
  output wire header_echo,
  // Parsed message units
  output reg unit_strobe,
  output reg unit_query,
  output reg unit_common,
  output reg [2:0] unit_words,
  output reg [1:0] unit_word_id,
  output reg unit_has_data,
  output reg [5:0] unit_data_pos,
  output reg msg_done
);

  localparam S_RX = 1'b0;
  localparam S_PARSE = 1'b1;
  localparam P_UNIT = 3'd0;
  localparam P_WSTART = 3'd1;
  localparam P_WORD = 3'd2;
  localparam P_QRY = 3'd3;
  localparam P_DATA = 3'd4;
  localparam P_SKIP = 3'd5;

  function [7:0] upc;
    input [7:0] c;
    begin
      upc = (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
    end
  endfunction

  // ========================================================
  // Configuration
  reg [`RMP_CFG_W-1:0] cfg_edit;
  reg [`RMP_CFG_W-1:0] cfg_act;
  reg echo;
  reg addr_rej;
  reg cmd_err;
  reg err_evt;
  reg resp_ok;
  reg tx_lf_next;

  wire wr_fire;
  wire acc = psel & penable;
  wire tx_reg = (paddr == `RMP_OFF_TX_DATA) | (paddr == `RMP_OFF_TX_END);
  wire tx_busy = tx_valid | tx_lf_next;
  // Stalling the bus is the only back-pressure; no reply queue is kept
  assign pready = ~(pwrite & tx_reg & tx_busy);
  assign wr_fire = acc & pwrite & pready;

  wire iface = cfg_act[`RMP_F_IFACE];
  assign parallel_bus_select = ~iface;
  assign serial_link_select = iface;
  assign bus_address = cfg_act[`RMP_F_ADDR];
  assign baud_19200 = cfg_act[`RMP_F_BAUD];
  assign header_echo = echo;

  wire confirm = confirm_key | (wr_fire & (paddr == `RMP_OFF_CONFIRM) &
                 pwdata[`RMP_F_CONFIRM]);
  wire bad_addr = ~cfg_edit[`RMP_F_IFACE] &
                  (cfg_edit[`RMP_F_ADDR] > `RMP_ADDR_MAX);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_edit <= `RMP_CFG_RST;
      cfg_act <= `RMP_CFG_RST;
      echo <= 1'b0;
      addr_rej <= 1'b0;
      cmd_err <= 1'b0;
    end else begin
      if (wr_fire && paddr == `RMP_OFF_CFG_EDIT) begin
        cfg_edit <= pwdata[`RMP_CFG_W-1:0];
      end
      if (wr_fire && paddr == `RMP_OFF_CTRL) begin
        echo <= pwdata[`RMP_F_ECHO];
      end
      if (wr_fire && paddr == `RMP_OFF_STATUS) begin
        if (pwdata[`RMP_F_ST_AREJ]) begin
          addr_rej <= 1'b0;
        end
        if (pwdata[`RMP_F_ST_CERR]) begin
          cmd_err <= 1'b0;
        end
      end
      // Edits sit unused until confirmed
      if (confirm) begin
        if (bad_addr) begin
          addr_rej <= 1'b1;
        end else begin
          cfg_act <= cfg_edit;
        end
      end
      if (err_evt) begin
        cmd_err <= 1'b1;
      end
    end
  end

  // ========================================================
  // Receive and buffer
  reg st;
  reg [7:0] buf_mem [0:`RMP_BUF_DEPTH-1];
  reg [`RMP_LEN_W-1:0] mlen;
  reg [`RMP_LEN_W-1:0] idx;
  reg last_cr;
  reg swallow_lf;
  reg ovf;

  assign rx_ready = (st == S_RX);
  wire [7:0] sel_data = iface ? ser_rx_data : par_rx_data;
  wire sel_valid = iface ? ser_rx_valid : par_rx_valid;
  wire eoi = par_rx_eoi & ~iface;
  wire is_lf = (sel_data == `RMP_CH_LF);
  wire is_cr = (sel_data == `RMP_CH_CR);
  wire rx_take = (st == S_RX) & sel_valid;
  wire room = (mlen < `RMP_BUF_DEPTH);
  // CR, CR+LF serial; LF, EOI, LF+EOI, CR+LF parallel
  wire term_now = rx_take & (iface ? is_cr : (is_lf | eoi));
  wire store_now = rx_take & room &
                   ~(iface ? (is_cr | (is_lf & swallow_lf)) : is_lf);
  wire [`RMP_LEN_W-1:0] mlen_inc = mlen + {{(`RMP_LEN_W-1){1'b0}}, 1'b1};

  always @(posedge pclk) begin
    if (store_now) begin
      buf_mem[mlen[5:0]] <= sel_data;
    end
  end

  // Upper panel keys pass only in the local state
  assign panel_key_accept = panel_key & ~remote_indicator;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_indicator <= 1'b0;
    end else if (rx_take) begin
      remote_indicator <= 1'b1;
    end else if (local_key) begin
      remote_indicator <= 1'b0;
    end
  end

  // ========================================================
  // Parser
  reg [2:0] ph;
  reg [3:0] wlen;
  reg [2:0] nwords;
  reg [7:0] units;
  reg common;
  reg query;
  reg has_data;
  reg [5:0] data_pos;
  reg [1:0] word_id;
  reg [`RMP_DICT_N-1:0] match;
  wire [`RMP_DICT_N-1:0] fin_ok;

  wire parse = (st == S_PARSE);
  wire eom = (idx == mlen);
  wire [7:0] ch = eom ? `RMP_CH_SEMI : upc(buf_mem[idx[5:0]]);
  wire alpha = (ch >= 8'h41) & (ch <= 8'h5a);
  wire alnum = alpha | ((ch >= 8'h30) & (ch <= 8'h39));
  wire start_w = parse & alpha & ((ph == P_UNIT) | (ph == P_WSTART));
  wire cont_w = parse & alnum & (ph == P_WORD);
  wire word_ok = common | (|fin_ok);
  // A new word compares from its first letter, not the old word's length
  wire [3:0] wpos = (start_w | (wlen > 4'd8)) ? 4'd0 : wlen;

  genvar g;
  generate
    for (g = 0; g < `RMP_DICT_N; g = g + 1) begin : dict
      localparam [287:0] STR = `RMP_DICT_STR;
      localparam [15:0] LL = `RMP_DICT_LONG;
      localparam [15:0] SL = `RMP_DICT_SHORT;
      wire [3:0] long_len = LL[15-4*g -: 4];
      wire [3:0] short_len = SL[15-4*g -: 4];
      wire [7:0] exp_ch = STR[(287-72*g) - 8*wpos -: 8];
      wire [3:0] pos = start_w ? 4'd0 : wlen;
      // Any length between short and long form is an error
      assign fin_ok[g] = match[g] &
                         ((wlen == long_len) | (wlen == short_len));
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          match[g] <= 1'b0;
        end else if (start_w || cont_w) begin
          match[g] <= (start_w | match[g]) & (pos < long_len) &
                      (ch == exp_ch);
        end
      end
    end
  endgenerate

  wire [1:0] next_id = fin_ok[0] ? 2'd0 : fin_ok[1] ? 2'd1 :
                       fin_ok[2] ? 2'd2 : 2'd3;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_RX;
      mlen <= {`RMP_LEN_W{1'b0}};
      idx <= {`RMP_LEN_W{1'b0}};
      last_cr <= 1'b0;
      swallow_lf <= 1'b0;
      ovf <= 1'b0;
      ph <= P_UNIT;
      wlen <= 4'h0;
      nwords <= 3'h0;
      units <= 8'h00;
      common <= 1'b0;
      query <= 1'b0;
      has_data <= 1'b0;
      data_pos <= 6'h00;
      word_id <= 2'h0;
      err_evt <= 1'b0;
      unit_strobe <= 1'b0;
      unit_query <= 1'b0;
      unit_common <= 1'b0;
      unit_words <= 3'h0;
      unit_word_id <= 2'h0;
      unit_has_data <= 1'b0;
      unit_data_pos <= 6'h00;
      msg_done <= 1'b0;
    end else begin
      err_evt <= 1'b0;
      unit_strobe <= 1'b0;
      msg_done <= 1'b0;
      case (st)
        S_RX: begin
          if (rx_take) begin
            swallow_lf <= iface & is_cr;
            if (store_now) begin
              mlen <= mlen_inc;
              last_cr <= is_cr;
            end else if (!room && !term_now) begin
              ovf <= 1'b1;
            end
            // Nothing is parsed before the terminator
            if (term_now) begin
              st <= S_PARSE;
              idx <= {`RMP_LEN_W{1'b0}};
              ph <= P_UNIT;
              units <= 8'h00;
              common <= 1'b0;
              query <= 1'b0;
              has_data <= 1'b0;
              nwords <= 3'h0;
              if (!iface && is_lf && last_cr) begin
                mlen <= mlen - {{(`RMP_LEN_W-1){1'b0}}, 1'b1};
              end
              if (ovf) begin
                ph <= P_SKIP;
                err_evt <= 1'b1;
              end
            end
          end
        end
        S_PARSE: begin
          if (!eom) begin
            idx <= idx + {{(`RMP_LEN_W-1){1'b0}}, 1'b1};
          end
          if (start_w) begin
            wlen <= 4'h1;
            ph <= P_WORD;
          end
          case (ph)
            P_UNIT: begin
              if (ch == `RMP_CH_COLON) begin
                ph <= P_WSTART;
              end else if (ch == `RMP_CH_STAR) begin
                common <= 1'b1;
                ph <= P_WSTART;
              end else if (!alpha) begin
                // An empty message or unit has no header
                if (!(eom && units != 8'h00)) begin
                  err_evt <= 1'b1;
                end
                ph <= P_SKIP;
              end
            end
            P_WSTART: begin
              if (!alpha) begin
                err_evt <= 1'b1;
                ph <= P_SKIP;
              end
            end
            P_WORD: begin
              if (alnum) begin
                wlen <= (wlen == 4'hf) ? wlen : wlen + 4'h1;
              end else if (!word_ok) begin
                err_evt <= 1'b1;
                ph <= P_SKIP;
              end else begin
                word_id <= next_id;
                if (ch == `RMP_CH_COLON && !common) begin
                  nwords <= nwords + 3'h1;
                  ph <= P_WSTART;
                end else if (ch == `RMP_CH_QM) begin
                  query <= 1'b1;
                  ph <= P_QRY;
                end else if (ch == `RMP_CH_SP) begin
                  has_data <= 1'b1;
                  data_pos <= idx[5:0] + 6'h01;
                  ph <= P_DATA;
                end else if (ch != `RMP_CH_SEMI) begin
                  err_evt <= 1'b1;
                  ph <= P_SKIP;
                end
              end
            end
            P_QRY: begin
              if (ch == `RMP_CH_SP) begin
                has_data <= 1'b1;
                data_pos <= idx[5:0] + 6'h01;
                ph <= P_DATA;
              end else if (ch != `RMP_CH_SEMI) begin
                err_evt <= 1'b1;
                ph <= P_SKIP;
              end
            end
            P_DATA: begin
            end
            P_SKIP: begin
            end
            default: begin
              ph <= P_SKIP;
            end
          endcase
          // End of a unit that parsed cleanly
          if (ch == `RMP_CH_SEMI && ph != P_SKIP && ph != P_UNIT &&
              ph != P_WSTART && (ph != P_WORD || word_ok)) begin
            unit_strobe <= 1'b1;
            unit_query <= query | (ph == P_WORD && 1'b0);
            unit_common <= common;
            unit_words <= nwords + 3'h1;
            unit_word_id <= (ph == P_WORD) ? next_id : word_id;
            unit_has_data <= has_data;
            unit_data_pos <= data_pos;
            units <= units + 8'h01;
            ph <= P_UNIT;
            common <= 1'b0;
            query <= 1'b0;
            has_data <= 1'b0;
            nwords <= 3'h0;
          end
          // A skipped tail runs out to the terminator only
          if (eom) begin
            st <= S_RX;
            mlen <= {`RMP_LEN_W{1'b0}};
            last_cr <= 1'b0;
            ovf <= 1'b0;
            msg_done <= 1'b1;
          end
        end
        default: begin
          st <= S_RX;
        end
      endcase
    end
  end

  // ========================================================
  // Response transmit
  wire tx_wr = wr_fire & tx_reg;
  wire pterm_crlf = cfg_act[`RMP_F_PTERM];
  wire sterm_crlf = cfg_act[`RMP_F_STERM];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_eoi <= 1'b0;
      tx_lf_next <= 1'b0;
      resp_ok <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        if (tx_lf_next) begin
          tx_data <= `RMP_CH_LF;
          tx_eoi <= ~iface;
          tx_lf_next <= 1'b0;
        end else begin
          tx_valid <= 1'b0;
          tx_eoi <= 1'b0;
        end
      end
      if (tx_wr && resp_ok) begin
        tx_valid <= 1'b1;
        if (paddr == `RMP_OFF_TX_DATA) begin
          tx_data <= upc(pwdata[7:0]);
        end else begin
          resp_ok <= 1'b0;
          if (iface) begin
            tx_data <= `RMP_CH_CR;
            tx_lf_next <= sterm_crlf;
          end else begin
            tx_data <= pterm_crlf ? `RMP_CH_CR : `RMP_CH_LF;
            tx_eoi <= ~pterm_crlf;
            tx_lf_next <= pterm_crlf;
          end
        end
      end
      // Only a query unit that parsed cleanly opens a reply
      if (unit_strobe && unit_query) begin
        resp_ok <= 1'b1;
      end
    end
  end

  // ========================================================
  // APB read and error answer
  wire known = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & ~penable & (~known | (pwrite & tx_reg & ~resp_ok));
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `RMP_OFF_CFG_EDIT: prdata[`RMP_CFG_W-1:0] <= cfg_edit;
          `RMP_OFF_CFG_ACT: prdata[`RMP_CFG_W-1:0] <= cfg_act;
          `RMP_OFF_CTRL: prdata[`RMP_F_ECHO] <= echo;
          `RMP_OFF_STATUS: begin
            prdata[`RMP_F_ST_REMOTE] <= remote_indicator;
            prdata[`RMP_F_ST_BUSY] <= parse;
            prdata[`RMP_F_ST_RESP] <= resp_ok;
            prdata[`RMP_F_ST_AREJ] <= addr_rej;
            prdata[`RMP_F_ST_CERR] <= cmd_err;
            prdata[`RMP_F_ST_UNITS] <= units;
          end
          `RMP_OFF_UNIT: begin
            prdata[13:0] <= {unit_data_pos, unit_has_data, unit_words,
                             unit_common, unit_query, unit_word_id};
          end
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// [tb/rmp_parser_sva.sv]
`include "rmp_regs.vh"

// ==========================================================
// Checker
module rmp_parser_sva (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Bus
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  // Receive
  input logic par_rx_valid,
  input logic par_rx_eoi,
  input logic ser_rx_valid,
  input logic rx_ready,
  // Transmit
  input logic [7:0] tx_data,
  input logic tx_valid,
  input logic tx_eoi,
  input logic tx_ready,
  // Panel and state
  input logic confirm_key,
  input logic local_key,
  input logic panel_key,
  input logic panel_key_accept,
  input logic remote_indicator,
  input logic parallel_bus_select,
  input logic serial_link_select,
  input logic [4:0] bus_address,
  input logic baud_19200,
  // Units
  input logic unit_strobe,
  input logic unit_query,
  input logic unit_common,
  input logic [2:0] unit_words,
  input logic [1:0] unit_word_id
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cfm_q;

  // Config may only move on the cycle after a confirm
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfm_q <= 1'b0;
    else
      cfm_q <= confirm_key || (psel && penable && pwrite && pready &&
        paddr == `RMP_OFF_CONFIRM && pwdata[0]);
  end

  chk_addr_limit: assert property (
    parallel_bus_select |-> bus_address <= 5'h1e)
    else $error("bus address above limit");
  chk_cfg_confirm: assert property (
    !cfm_q |-> $stable({parallel_bus_select, bus_address, baud_19200}))
    else $error("config moved without confirm");
  chk_remote_entry: assert property (
    rx_ready && ((par_rx_valid && parallel_bus_select) ||
    (ser_rx_valid && serial_link_select)) |=> remote_indicator)
    else $error("traffic did not enter remote");
  chk_panel_block: assert property (
    panel_key_accept == (panel_key && !remote_indicator))
    else $error("panel key gating wrong");
  chk_local_exit: assert property (
    local_key && !par_rx_valid && !ser_rx_valid |=> !remote_indicator)
    else $error("local key did not leave remote");
  chk_unit_hold: assert property (
    !unit_strobe |->
    $stable({unit_query, unit_common, unit_words, unit_word_id}))
    else $error("unit fields moved without strobe");
  chk_tx_upper: assert property (
    tx_valid |-> !(tx_data >= 8'h61 && tx_data <= 8'h7a))
    else $error("lower case reply byte");
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable({tx_eoi, tx_data}))
    else $error("reply byte dropped or changed");
  chk_parse_wait: assert property (
    parallel_bus_select && par_rx_valid && par_rx_eoi && rx_ready
    |=> !rx_ready) else $error("end byte did not start parse");
  chk_apb_nowait: assert property (
    psel && !penable && !(pwrite && paddr[7:3] == 5'h03) |=> pready)
    else $error("register access stalled");
endmodule

bind rmp_parser rmp_parser_sva rmp_parser_sva_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .par_rx_valid(par_rx_valid), .par_rx_eoi(par_rx_eoi),
  .ser_rx_valid(ser_rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_eoi(tx_eoi), .tx_ready(tx_ready),
  .confirm_key(confirm_key), .local_key(local_key),
  .panel_key(panel_key), .panel_key_accept(panel_key_accept),
  .remote_indicator(remote_indicator),
  .parallel_bus_select(parallel_bus_select),
  .serial_link_select(serial_link_select), .bus_address(bus_address),
  .baud_19200(baud_19200), .unit_strobe(unit_strobe),
  .unit_query(unit_query), .unit_common(unit_common),
  .unit_words(unit_words), .unit_word_id(unit_word_id)
);

// [tb/rmp_host.sv]
// ==========================================================
// Host controller model
module rmp_host (
  // Clock and flow
  input logic pclk,
  input logic rx_ready,
  // Reply side
  input logic [7:0] tx_data,
  input logic tx_valid,
  input logic tx_eoi,
  output logic tx_ready,
  // Byte streams
  output logic [7:0] par_rx_data,
  output logic par_rx_valid,
  output logic par_rx_eoi,
  output logic [7:0] ser_rx_data,
  output logic ser_rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  logic [8:0] got[$];

  initial begin
    par_rx_data = 8'h00;
    par_rx_valid = 1'b0;
    par_rx_eoi = 1'b0;
    ser_rx_data = 8'h00;
    ser_rx_valid = 1'b0;
    tx_ready = 1'b1;
  end

  // Slow sink stalls every other cycle to stress reply holding
  always @(posedge pclk) begin
    if (tx_valid && tx_ready)
      got.push_back({tx_eoi, tx_data});
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // Sends the string as given, one byte per take; EOI only on the last
  task automatic send(input string s, input bit ser, input bit eoi);
    bit ok;
    for (int i = 0; i < s.len(); i++) begin
      if (ser) begin
        ser_rx_data <= s[i];
        ser_rx_valid <= 1'b1;
      end else begin
        par_rx_data <= s[i];
        par_rx_valid <= 1'b1;
        par_rx_eoi <= eoi && i == s.len() - 1;
      end
      do begin
        @(negedge pclk);
        ok = rx_ready;
        @(posedge pclk);
      end while (!ok);
    end
    // Released lines never keep showing the last byte
    // Only the used lines: a send on the other link may start now
    if (ser) begin
      ser_rx_data <= ~ser_rx_data;
      ser_rx_valid <= 1'b0;
    end else begin
      par_rx_data <= ~par_rx_data;
      par_rx_valid <= 1'b0;
      par_rx_eoi <= 1'b0;
    end
  endtask
endmodule

// [tb/rmp_parser_tb.sv]
`include "rmp_regs.vh"

// ==========================================================
// Testbench
module rmp_parser_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic confirm_key = 1'b0;
  logic local_key = 1'b0;
  logic panel_key = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rx_ready, tx_valid, tx_eoi, tx_ready, rerr;
  logic [7:0] par_rx_data, ser_rx_data, tx_data;
  logic par_rx_valid, par_rx_eoi, ser_rx_valid, panel_key_accept;
  logic remote_indicator, parallel_bus_select, serial_link_select;
  logic baud_19200, header_echo, unit_strobe, unit_query, unit_common;
  logic unit_has_data, msg_done;
  logic [4:0] bus_address;
  logic [2:0] unit_words;
  logic [1:0] unit_word_id;
  logic [5:0] unit_data_pos;
  logic [7:0] uq[$];
  int n_fail = 0;
  int check_count = 0;
  int n_done = 0;
  string bad[4] = '{"FREQU 5;*RST\n", "1AB\n", " 5\n", "FREQU?\n"};
  string term[4] = '{"*RST\n", "*RST\r\n", "*RST", "*RST\n"};
  bit teoi[4] = '{0, 0, 1, 1};

  always #20 pclk = ~pclk;

  rmp_parser rmp_parser_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .par_rx_data(par_rx_data),
    .par_rx_valid(par_rx_valid), .par_rx_eoi(par_rx_eoi),
    .ser_rx_data(ser_rx_data), .ser_rx_valid(ser_rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_eoi(tx_eoi), .tx_ready(tx_ready), .confirm_key(confirm_key),
    .local_key(local_key), .panel_key(panel_key),
    .panel_key_accept(panel_key_accept),
    .remote_indicator(remote_indicator),
    .parallel_bus_select(parallel_bus_select),
    .serial_link_select(serial_link_select), .bus_address(bus_address),
    .baud_19200(baud_19200), .header_echo(header_echo),
    .unit_strobe(unit_strobe), .unit_query(unit_query),
    .unit_common(unit_common), .unit_words(unit_words),
    .unit_word_id(unit_word_id), .unit_has_data(unit_has_data),
    .unit_data_pos(unit_data_pos), .msg_done(msg_done)
  );

  rmp_host rmp_host_inst (
    .pclk(pclk), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_eoi(tx_eoi), .tx_ready(tx_ready),
    .par_rx_data(par_rx_data), .par_rx_valid(par_rx_valid),
    .par_rx_eoi(par_rx_eoi), .ser_rx_data(ser_rx_data),
    .ser_rx_valid(ser_rx_valid)
  );

  always @(posedge pclk) begin
    if (unit_strobe)
      uq.push_back({unit_has_data, unit_query, unit_common, unit_words,
        unit_word_id});
    if (msg_done === 1'b1)
      n_done++;
  end

  task automatic check(input string n, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    bit ok;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      ok = pready;
      rdat = prdata;
      rerr = pslverr;
    end while (!ok);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic msg(input string s, input bit ser, input bit eoi);
    int d0;
    uq.delete();
    d0 = n_done;
    rmp_host_inst.send(s, ser, eoi);
    // A serial CR+LF ends parsing before the LF is even taken
    for (int i = 0; i < 300 && n_done == d0; i++)
      @(negedge pclk);
    check("msg done", n_done != d0, 1'b1);
    repeat (2) @(posedge pclk);
  endtask

  task automatic reply(input logic [7:0] c, input int n);
    rmp_host_inst.got.delete();
    apb(1'b1, `RMP_OFF_TX_DATA, {24'h0, c});
    apb(1'b1, `RMP_OFF_TX_END, 32'h0);
    for (int i = 0; i < 100 && rmp_host_inst.got.size() < n; i++)
      @(posedge pclk);
    check("tx count", rmp_host_inst.got.size(), n);
  endtask

  task report_and_stop;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `RMP_OFF_CFG_ACT, 0);
    check("cfg_act", rdat, 32'h102);
    check("echo", header_echo, 1'b0);
    apb(0, 8'h20, 0);
    check("unmapped", rerr, 1'b1);
    for (int i = 0; i < 4; i++) begin
      msg(term[i], 1'b0, teoi[i]);
      check("units", uq.size(), 1);
      check("common", uq[0][6:5], 2'b01);
    end
    check("remote", remote_indicator, 1'b1);
    panel_key <= 1'b1;
    @(posedge pclk);
    check("panel", panel_key_accept, 1'b0);
    local_key <= 1'b1;
    @(posedge pclk);
    local_key <= 1'b0;
    @(posedge pclk);
    check("local", remote_indicator, 1'b0);
    check("panel", panel_key_accept, 1'b1);
    rmp_host_inst.slow = 1'b1;
    msg(":beep:key?\n", 1'b0, 1'b0);
    check("unit", uq[0], 8'h4b);
    reply(8'h61, 2);
    check("tx0", rmp_host_inst.got[0], 9'h041);
    check("tx1", rmp_host_inst.got[1], 9'h10a);
    msg("FREQ 5\n", 1'b0, 1'b0);
    check("unit", uq[0], 8'h85);
    check("data pos", unit_data_pos, 6'd5);
    foreach (bad[i]) begin
      msg(bad[i], 1'b0, 1'b0);
      check("units", uq.size(), 0);
      apb(0, `RMP_OFF_STATUS, 0);
      check("cmd err", rdat[4], 1'b1);
      apb(1, `RMP_OFF_STATUS, 32'h10);
    end
    apb(1, `RMP_OFF_TX_DATA, 32'h41);
    check("no reply", rerr, 1'b1);
    apb(1, `RMP_OFF_CTRL, 32'h1);
    check("echo", header_echo, 1'b1);
    apb(1, `RMP_OFF_CFG_EDIT, 32'h13e);
    apb(1, `RMP_OFF_CONFIRM, 32'h1);
    apb(0, `RMP_OFF_STATUS, 0);
    check("addr rej", rdat[3], 1'b1);
    check("addr kept", bus_address, 5'h01);
    apb(1, `RMP_OFF_CFG_EDIT, 32'h1c1);
    apb(0, `RMP_OFF_CFG_ACT, 0);
    check("unconfirmed", rdat, 32'h102);
    confirm_key <= 1'b1;
    @(posedge pclk);
    confirm_key <= 1'b0;
    apb(0, `RMP_OFF_CFG_ACT, 0);
    check("cfg_act", rdat, 32'h1c1);
    check("baud", baud_19200, 1'b1);
    check("serial", serial_link_select, 1'b1);
    rmp_host_inst.send("*RST\n", 1'b0, 1'b1);
    msg("HEADER?\r\n", 1'b1, 1'b0);
    check("units", uq.size(), 1);
    check("unit", uq[0], 8'h44);
    reply(8'h78, 3);
    check("tx0", rmp_host_inst.got[0][7:0], 8'h58);
    check("tx1", rmp_host_inst.got[1][7:0], 8'h0d);
    check("tx2", rmp_host_inst.got[2][7:0], 8'h0a);
    report_and_stop();
  end
endmodule
